/* wdt_pkg.sv */
// Package with constants for the windowed watchdog timer
package wdt_pkg;

    // Timeout select encodings
    localparam logic [1:0] WDT_TSEL_OFF = 2'h0;
    localparam logic [1:0] WDT_TSEL_SHORT = 2'h1;
    localparam logic [1:0] WDT_TSEL_MID = 2'h2;
    localparam logic [1:0] WDT_TSEL_LONG = 2'h3;

    // Clock select encodings
    localparam logic WDT_CLK_TICK = 1'b0;
    localparam logic WDT_CLK_BUS = 1'b1;

    // Service key values
    localparam logic [15:0] WDT_KEY_FIRST = 16'h0055;
    localparam logic [15:0] WDT_KEY_SECOND = 16'h00aa;

    // Counter width covers the longest bus timeout
    localparam int WDT_CNT_W = 19;

    // Overflow counts, 1 kHz tick
    localparam logic [WDT_CNT_W-1:0] WDT_TICK_OVF_SHORT = 19'h00020;
    localparam logic [WDT_CNT_W-1:0] WDT_TICK_OVF_MID = 19'h00100;
    localparam logic [WDT_CNT_W-1:0] WDT_TICK_OVF_LONG = 19'h00400;

    // Overflow counts, bus clock
    localparam logic [WDT_CNT_W-1:0] WDT_BUS_OVF_SHORT = 19'h02000;
    localparam logic [WDT_CNT_W-1:0] WDT_BUS_OVF_MID = 19'h10000;
    localparam logic [WDT_CNT_W-1:0] WDT_BUS_OVF_LONG = 19'h40000;

    // Window opening counts, bus clock (75 percent of the period)
    localparam logic [WDT_CNT_W-1:0] WDT_WIN_SHORT = 19'h01800;
    localparam logic [WDT_CNT_W-1:0] WDT_WIN_MID = 19'h0c000;
    localparam logic [WDT_CNT_W-1:0] WDT_WIN_LONG = 19'h30000;

    // Tick period and its cycle count at the 100 MHz clock
    localparam int WDT_CLK_PERIOD_NS = 10;
    localparam int WDT_TICK_PERIOD_NS = 1000000;
    localparam int WDT_TICK_CYCLES = WDT_TICK_PERIOD_NS / WDT_CLK_PERIOD_NS;

    // Service sequence states
    typedef enum logic {
        WDT_SEQ_IDLE,
        WDT_SEQ_ARMED
    } wdt_seq_t;

endpackage

/* wdt_tick_gen.sv */
// Divider that makes the low power tick strobe
`timescale 1ns/1ps
module wdt_tick_gen #(
    parameter int DIVIDE = 100000
) (
    input wire logic clock_i,
    input wire logic rst_i,
    output logic tick_o
);
    localparam int CW = $clog2(DIVIDE);

    typedef struct packed {
        logic [CW-1:0] count;
        logic tick;
    } wdt_tick_state_t;

    wdt_tick_state_t state;
    wdt_tick_state_t next_state;

    // Free-running divider, one-cycle strobe per wrap
    always_comb begin
        next_state = state;
        next_state.tick = 1'b0;
        if (state.count == CW'(DIVIDE - 1)) begin
            next_state.count = '0;
            next_state.tick = 1'b1;
        end else begin
            next_state.count = state.count + CW'(1);
        end
    end

    // State register
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign tick_o = state.tick;
endmodule

/* wdt_core.sv */
// Windowed watchdog timer core with service-key checking
`timescale 1ns/1ps
module wdt_core
    import wdt_pkg::*;
#(
    parameter int TICK_CYCLES = WDT_TICK_CYCLES
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [1:0] timeout_select_i,
    input wire logic clock_select_i,
    input wire logic window_mode_enable_i,
    input wire logic service_write_i,
    input wire logic [15:0] service_data_i,
    input wire logic [7:0] reset_status_i,
    output logic [7:0] reset_status_register_o,
    output logic system_reset_o,
    output logic [WDT_CNT_W-1:0] count_o,
    output logic window_open_o
);
    // ==========================================================
    // Tick source
    // ==========================================================
    logic tick;

    wdt_tick_gen #(
        .DIVIDE(TICK_CYCLES)
    ) u_tick (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .tick_o(tick)
    );

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        logic [WDT_CNT_W-1:0] count;
        wdt_seq_t seq;
        logic reset_req;
        logic window_open;
        logic [7:0] status;
    } wdt_state_t;

    wdt_state_t state;
    wdt_state_t next_state;

    logic enabled;
    logic step;
    logic window_active;
    logic [WDT_CNT_W-1:0] overflow;
    logic [WDT_CNT_W-1:0] window_start;

    // ==========================================================
    // Configuration decode
    // ==========================================================
    // Overflow and window thresholds from the clock and timeout fields
    always_comb begin
        overflow = WDT_TICK_OVF_LONG;
        window_start = '0;
        if (clock_select_i == WDT_CLK_BUS) begin
            case (timeout_select_i)
                WDT_TSEL_SHORT: begin
                    overflow = WDT_BUS_OVF_SHORT;
                    window_start = WDT_WIN_SHORT;
                end
                WDT_TSEL_MID: begin
                    overflow = WDT_BUS_OVF_MID;
                    window_start = WDT_WIN_MID;
                end
                default: begin
                    overflow = WDT_BUS_OVF_LONG;
                    window_start = WDT_WIN_LONG;
                end
            endcase
        end else begin
            case (timeout_select_i)
                WDT_TSEL_SHORT: overflow = WDT_TICK_OVF_SHORT;
                WDT_TSEL_MID: overflow = WDT_TICK_OVF_MID;
                default: overflow = WDT_TICK_OVF_LONG;
            endcase
        end
    end

    assign enabled = (timeout_select_i != WDT_TSEL_OFF);
    // Bus clock counts every cycle; the tick clock only on strobes
    assign step = (clock_select_i == WDT_CLK_BUS) ? 1'b1 : tick;
    // Window only exists on the bus clock
    assign window_active = window_mode_enable_i && (clock_select_i == WDT_CLK_BUS);

    // ==========================================================
    // Next-state logic
    // ==========================================================
    // Service check has priority over counting so a good key in the last
    // cycle still rescues the system.
    always_comb begin
        next_state = state;
        next_state.reset_req = 1'b0;
        // Status is read-only: only the system status input updates it
        next_state.status = reset_status_i;
        next_state.window_open = window_active && (state.count >= window_start);
        if (!enabled) begin
            next_state.count = '0;
            next_state.seq = WDT_SEQ_IDLE;
        end else if (service_write_i) begin
            if (window_active && (state.count < window_start)) begin
                next_state.reset_req = 1'b1;
                next_state.count = '0;
                next_state.seq = WDT_SEQ_IDLE;
            end else if (service_data_i == WDT_KEY_FIRST) begin
                next_state.seq = WDT_SEQ_ARMED;
                if (step) begin
                    next_state.count = state.count + WDT_CNT_W'(1);
                end
            end else if (service_data_i == WDT_KEY_SECOND) begin
                if (state.seq == WDT_SEQ_ARMED) begin
                    next_state.count = '0;
                end else if (step) begin
                    next_state.count = state.count + WDT_CNT_W'(1);
                end
                next_state.seq = WDT_SEQ_IDLE;
            end else begin
                next_state.reset_req = 1'b1;
                next_state.count = '0;
                next_state.seq = WDT_SEQ_IDLE;
            end
        end else if (step) begin
            if (state.count + WDT_CNT_W'(1) >= overflow) begin
                next_state.reset_req = 1'b1;
                next_state.count = '0;
                next_state.seq = WDT_SEQ_IDLE;
            end else begin
                next_state.count = state.count + WDT_CNT_W'(1);
            end
        end
    end

    // ==========================================================
    // State register
    // ==========================================================
    // Counter starts from zero after any reset
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign reset_status_register_o = state.status;
    assign system_reset_o = state.reset_req;
    assign count_o = state.count;
    assign window_open_o = state.window_open;
endmodule

/* wdt_timer_top.sv */
// Top level: option registers with documented reset defaults around the core
`timescale 1ns/1ps
module wdt_timer_top
    import wdt_pkg::*;
#(
    parameter int TICK_CYCLES = WDT_TICK_CYCLES
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic config_write_i,
    input wire logic [1:0] timeout_select_i,
    input wire logic clock_select_i,
    input wire logic window_mode_enable_i,
    input wire logic service_write_i,
    input wire logic [15:0] service_data_i,
    input wire logic [7:0] reset_status_i,
    output logic [7:0] reset_status_register_o,
    output logic system_reset_o,
    output logic [WDT_CNT_W-1:0] count_o,
    output logic window_open_o
);
    // ==========================================================
    // Options
    // ==========================================================
    typedef struct packed {
        logic [1:0] tsel;
        logic csel;
        logic wmode;
    } wdt_opt_t;

    wdt_opt_t opt;
    wdt_opt_t next_opt;

    // Options load on a config write; reset gives tick clock, longest timeout
    always_comb begin
        next_opt = opt;
        if (config_write_i) begin
            next_opt.tsel = timeout_select_i;
            next_opt.csel = clock_select_i;
            next_opt.wmode = window_mode_enable_i;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            opt <= '{tsel: WDT_TSEL_LONG, csel: WDT_CLK_TICK, wmode: 1'b0};
        end else begin
            opt <= next_opt;
        end
    end

    wdt_core #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_core (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .timeout_select_i(opt.tsel),
        .clock_select_i(opt.csel),
        .window_mode_enable_i(opt.wmode),
        .service_write_i(service_write_i),
        .service_data_i(service_data_i),
        .reset_status_i(reset_status_i),
        .reset_status_register_o(reset_status_register_o),
        .system_reset_o(system_reset_o),
        .count_o(count_o),
        .window_open_o(window_open_o)
    );
endmodule

/* wdt_timer_sva.sv */
// Assertion checker for the windowed watchdog timer top
`timescale 1ns/1ps
module wdt_timer_sva
    import wdt_pkg::*;
#(
    parameter int TICK_CYCLES = WDT_TICK_CYCLES
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic config_write_i,
    input wire logic [1:0] timeout_select_i,
    input wire logic clock_select_i,
    input wire logic window_mode_enable_i,
    input wire logic service_write_i,
    input wire logic [15:0] service_data_i,
    input wire logic [7:0] reset_status_i,
    input wire logic [7:0] reset_status_register_o,
    input wire logic system_reset_o,
    input wire logic [WDT_CNT_W-1:0] count_o,
    input wire logic window_open_o
);
    // ==========================================================
    // Properties; a running counter stands in for "enabled"
    default clocking @(posedge clock_i);
    endclocking
    default disable iff (rst_i);
    property p_pulse_one; system_reset_o |=> !system_reset_o; endproperty
    a_pulse_one: assert property (p_pulse_one) else $error("reset pulse too long");
    property p_zero_at_pulse; system_reset_o |-> count_o == 0; endproperty
    a_zero_at_pulse: assert property (p_zero_at_pulse) else $error("count not cleared by reset");
    property p_mirror; !$past(rst_i) |-> reset_status_register_o == $past(reset_status_i); endproperty
    a_mirror: assert property (p_mirror) else $error("status copy wrong");
    property p_bad_key; service_write_i && !config_write_i && count_o != 0 && service_data_i != WDT_KEY_FIRST
        && service_data_i != WDT_KEY_SECOND |=> system_reset_o; endproperty
    a_bad_key: assert property (p_bad_key) else $error("illegal write gave no reset");
    property p_key_clear; service_write_i && service_data_i == WDT_KEY_SECOND && $past(service_write_i)
        && $past(service_data_i) == WDT_KEY_FIRST |=> count_o == 0; endproperty
    a_key_clear: assert property (p_key_clear) else $error("key pair did not clear count");
    property p_window_rise; $rose(window_open_o) |-> count_o >= WDT_WIN_SHORT; endproperty
    a_window_rise: assert property (p_window_rise) else $error("window opened early");
    property p_count_step; count_o != 0 |-> count_o == $past(count_o) + 19'h1 || count_o == $past(count_o);
    endproperty
    a_count_step: assert property (p_count_step) else $error("count jumped");
    property p_cause; system_reset_o |-> $past(service_write_i) || $past(count_o) != 0; endproperty
    a_cause: assert property (p_cause) else $error("reset without cause");
    property p_quiet; $fell(rst_i) |-> count_o == 0 && !system_reset_o; endproperty
    a_quiet: assert property (p_quiet) else $error("outputs not clear after reset");
endmodule

bind wdt_timer_top wdt_timer_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (.clock_i(clock_i), .rst_i(rst_i),
    .config_write_i(config_write_i), .timeout_select_i(timeout_select_i), .clock_select_i(clock_select_i),
    .window_mode_enable_i(window_mode_enable_i), .service_write_i(service_write_i),
    .service_data_i(service_data_i), .reset_status_i(reset_status_i),
    .reset_status_register_o(reset_status_register_o), .system_reset_o(system_reset_o), .count_o(count_o),
    .window_open_o(window_open_o));

/* windowed_watchdog_timer_bench.sv */
// Self-checking testbench for the windowed watchdog timer
`timescale 1ns/1ps
module windowed_watchdog_timer_bench;
    import wdt_pkg::*;
    logic clock_i = 1'b0, rst_i = 1'b1, cw = 1'b0, cs = 1'b0, wm = 1'b0, sw = 1'b0, sr, wo, p;
    logic [1:0] ts = 2'h0;
    logic [15:0] sd = 16'h0000;
    logic [7:0] rs = 8'h00, st;
    logic [WDT_CNT_W-1:0] cnt;
    int fail_count = 0, check_count = 0, n;

    // Tick shortened to 4 clocks so the long tick timeouts fit the run
    wdt_timer_top #(.TICK_CYCLES(4)) dut (.clock_i(clock_i), .rst_i(rst_i), .config_write_i(cw),
        .timeout_select_i(ts), .clock_select_i(cs), .window_mode_enable_i(wm), .service_write_i(sw),
        .service_data_i(sd), .reset_status_i(rs), .reset_status_register_o(st), .system_reset_o(sr),
        .count_o(cnt), .window_open_o(wo));

    // ==========================================================
    // Helpers; inputs always move 1 ns after the rising edge
    task automatic step(input int k);
        repeat (k) @(posedge clock_i);
        #1;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Two spare cycles let the new options settle before any write
    task automatic cfg(input logic [1:0] t, input logic c, input logic w);
        ts = t;
        cs = c;
        wm = w;
        cw = 1'b1;
        step(1);
        cw = 1'b0;
        step(2);
    endtask
    // One write; p records a reset pulse in either of the next two cycles
    task automatic put(input logic [15:0] d);
        sw = 1'b1;
        sd = d;
        step(1);
        sw = 1'b0;
        p = sr;
        step(1);
        p = p | sr;
    endtask
    task automatic keys();
        sw = 1'b1;
        sd = WDT_KEY_FIRST;
        step(1);
        sd = WDT_KEY_SECOND;
        step(1);
        sw = 1'b0;
        p = sr;
        step(1);
        p = p | sr;
    endtask
    task automatic wait_pulse(input int lim);
        n = 0;
        while (sr !== 1'b1 && n < lim) begin
            step(1);
            n++;
        end
    endtask
    task automatic end_of_test();
        if (fail_count == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_default();
        wait_pulse(5000);
        chk("default expiry", 32'(n >= 4088 && n <= 4104), 32'h1);
    endtask
    task automatic t_tick();
        int e;
        for (int k = 1; k < 4; k++) begin
            e = 4 << (k == 1 ? 5 : (k == 2 ? 8 : 10));
            cfg(2'(k), WDT_CLK_TICK, 1'b0);
            put(16'h0012);
            chk("bad key pulse", 32'(p), 32'h1);
            wait_pulse(5000);
            chk("tick expiry", 32'(n + 8 >= e && n <= e + 8), 32'h1);
        end
    endtask
    task automatic t_bus();
        cfg(WDT_TSEL_SHORT, WDT_CLK_BUS, 1'b0);
        put(16'h0000);
        wait_pulse(9000);
        chk("bus expiry", 32'(n >= 8184 && n <= 8196), 32'h1);
        step(100);
        rs = 8'h3c;
        keys();
        chk("service pulse", 32'(p), 32'h0);
        chk("service clear", 32'(cnt < 19'h4), 32'h1);
        chk("status copy", 32'(st), 32'h3c);
        step(100);
        put(WDT_KEY_SECOND);
        chk("lone second key pulse", 32'(p), 32'h0);
        chk("lone second key kept count", 32'(cnt >= 19'h64), 32'h1);
    endtask
    task automatic t_window();
        cfg(WDT_TSEL_SHORT, WDT_CLK_BUS, 1'b1);
        put(16'h0034);
        step(100);
        put(WDT_KEY_FIRST);
        chk("early write pulse", 32'(p), 32'h1);
        n = 0;
        while (wo !== 1'b1 && n < 7000) begin
            step(1);
            n++;
        end
        chk("window opening", 32'(n >= 6130 && n <= 6150), 32'h1);
        keys();
        chk("window service pulse", 32'(p), 32'h0);
        chk("window service clear", 32'(cnt < 19'h4), 32'h1);
    endtask
    task automatic t_tick_window();
        cfg(WDT_TSEL_LONG, WDT_CLK_TICK, 1'b1);
        put(16'h0077);
        step(20);
        keys();
        chk("tick early service pulse", 32'(p), 32'h0);
        chk("tick window flag", 32'(wo), 32'h0);
    endtask
    task automatic t_off();
        cfg(WDT_TSEL_OFF, WDT_CLK_BUS, 1'b0);
        put(16'h0012);
        chk("disabled write pulse", 32'(p), 32'h0);
        wait_pulse(9000);
        chk("disabled expiry", 32'(n), 32'd9000);
        chk("disabled count", 32'(cnt), 32'h0);
    endtask
    // A second reset must bring back the tick clock and longest timeout even from the disabled setting
    task automatic t_again();
        rst_i = 1'b1;
        step(2);
        rst_i = 1'b0;
        wait_pulse(5000);
        chk("expiry after second reset", 32'(n >= 4088 && n <= 4104), 32'h1);
    endtask

    // ==========================================================
    // Clock, reset, sequence and hang guard
    initial begin
        forever #5 clock_i = ~clock_i;
    end
    initial begin
        repeat (20) @(posedge clock_i);
        #1;
        rst_i = 1'b0;
        t_default();
        t_tick();
        t_bus();
        t_window();
        t_tick_window();
        t_off();
        t_again();
        end_of_test();
    end
    // Whole run is near 37k cycles; 90k cycles means a hang
    initial begin
        #900000;
        fail_count++;
        end_of_test();
    end
endmodule
